// ===== testbench/testbench.sv
// Self-checking bench for the two-pair converter trigger control block.
`timescale 1ns/1ps
module testbench;
	import acp_pkg::*;
	logic core_clk = 1'b0; // System clock, 100 MHz.
	logic rst_n = 1'b0; // Asynchronous reset, active low.
	acp_bus_req_s busReq = '0; // Register port request.
	logic [PAIRS-1:0] hwTriggerIn = '0; // Hardware trigger pulses.
	logic convBusy = 1'b0; // Converter core busy level.
	logic [PAIRS-1:0] convDone = '0; // Completion pulses.
	logic [DATA_W-1:0] rdData; // Read data, one cycle after the strobe.
	logic [PAIRS-1:0] convStart; // Start pulses per pair.
	logic irq; // Interrupt level.
	logic [DATA_W-1:0] v; // Last value read.
	int n_mismatch = 0;
	int compares = 0;
	// Soft source word for the low pair; the source is written first so the trigger is legal.
	localparam logic [DATA_W-1:0] SOFT_SRC = {8'h00, 3'b000, SRC_SOFTWARE};
	acp_pair_trigger_control u_dut (.core_clk(core_clk), .rst_n(rst_n), .busReq(busReq),
		.hwTriggerIn(hwTriggerIn), .convBusy(convBusy), .convDone(convDone),
		.rdData(rdData), .convStart(convStart), .irq(irq));
	// Free-running clock.
	always #5 core_clk = ~core_clk;
	// Compare a seen value against the expected one and count it.
	task automatic chk(input string name, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One write cycle; the strobe drops at the edge that takes it.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk) busReq <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: d};
		@(posedge core_clk) busReq <= '0;
	endtask
	// One read cycle; data are sampled in the single cycle where they stand.
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge core_clk) busReq <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: '0};
		@(posedge core_clk) busReq <= '0;
		#1 v = rdData;
	endtask
	// Reset values, read-write bits and an unmapped index.
	task automatic t_regs();
		rd(OFF_CONTROL); chk("control reset", v, RST_CONTROL);
		rd(OFF_IRQ_STATUS); chk("status reset", v, 16'h0000);
		rd(4'hf); chk("unmapped", v, 16'h0000);
		rd(OFF_IRQ_MASK); chk("mask reset", v, 16'h0000);
		rd(OFF_BUSY); chk("busy idle", v, 16'h0000);
		wr(OFF_CONTROL, 16'h9a8b);
		rd(OFF_CONTROL); chk("control rw", v, 16'h9a8b);
		wr(OFF_CONTROL, 16'h0000);
		rd(OFF_CONTROL); chk("control clear", v, 16'h0000);
		$display("test regs done");
	endtask
	// High pair hardware trigger with interrupt enabled, cleared, then masked.
	task automatic t_hw_irq();
		wr(OFF_CONTROL, 16'h8000);
		wr(OFF_IRQ_MASK, 16'h0003);
		rd(OFF_IRQ_MASK); chk("mask rw", v, 16'h0003);
		@(posedge core_clk) hwTriggerIn <= 2'b10;
		@(posedge core_clk) hwTriggerIn <= 2'b00;
		#1 chk("start hi", 16'(convStart), 16'h0002);
		rd(OFF_CONTROL); chk("pending hi", v, 16'hc000);
		@(posedge core_clk) convDone <= 2'b10;
		@(posedge core_clk) convDone <= 2'b00;
		repeat (2) @(posedge core_clk);
		#1 chk("irq hi", 16'(irq), 16'h0001);
		rd(OFF_CONTROL); chk("done hi", v, 16'h8000);
		rd(OFF_IRQ_STATUS); chk("status hi", v, 16'h0002);
		wr(OFF_IRQ_STATUS, 16'h0002);
		repeat (2) @(posedge core_clk);
		#1 chk("irq cleared", 16'(irq), 16'h0000);
		@(posedge core_clk) hwTriggerIn <= 2'b10;
		@(posedge core_clk) hwTriggerIn <= 2'b00;
		wr(OFF_IRQ_MASK, 16'h0000);
		@(posedge core_clk) convDone <= 2'b10;
		@(posedge core_clk) convDone <= 2'b00;
		repeat (3) @(posedge core_clk);
		#1 chk("irq masked", 16'(irq), 16'h0000);
		rd(OFF_IRQ_STATUS); chk("status once", v, 16'h0002);
		wr(OFF_IRQ_STATUS, 16'h0003);
		wr(OFF_CONTROL, 16'h0000);
		$display("test hw irq done");
	endtask
	// Low pair with interrupt disabled: pending still clears, no status.
	task automatic t_noirq();
		wr(OFF_IRQ_MASK, 16'h0003);
		@(posedge core_clk) hwTriggerIn <= 2'b01;
		@(posedge core_clk) hwTriggerIn <= 2'b00;
		rd(OFF_CONTROL); chk("pending lo", v, 16'h0040);
		@(posedge core_clk) convDone <= 2'b01;
		@(posedge core_clk) convDone <= 2'b00;
		rd(OFF_CONTROL); chk("done lo", v, 16'h0000);
		rd(OFF_IRQ_STATUS); chk("no status", v, 16'h0000);
		#1 chk("no irq", 16'(irq), 16'h0000);
		$display("test no irq done");
	endtask
	// Soft trigger held while the converter is busy, then started once free.
	task automatic t_soft();
		int i;
		@(posedge core_clk) convBusy <= 1'b1;
		wr(OFF_CONTROL, SOFT_SRC);
		wr(OFF_CONTROL, SOFT_SRC | 16'h0020);
		for (i = 0; i < 5; i++) begin
			@(posedge core_clk) #1 chk("held start", 16'(convStart), 16'h0000);
		end
		rd(OFF_CONTROL); chk("soft held", v, SOFT_SRC | 16'h0020);
		@(posedge core_clk) convBusy <= 1'b0;
		i = 0;
		while (convStart[0] !== 1'b1 && i < 20) begin
			@(posedge core_clk) #1 i++;
		end
		chk("soft start", 16'(convStart), 16'h0001);
		// Keep the core busy so the sequencer must still report its start in flight.
		@(posedge core_clk) convBusy <= 1'b1;
		rd(OFF_BUSY); chk("busy in flight", v, 16'h0001);
		@(posedge core_clk) convBusy <= 1'b0;
		rd(OFF_CONTROL); chk("soft cleared", v, SOFT_SRC | 16'h0040);
		@(posedge core_clk) convDone <= 2'b01;
		@(posedge core_clk) convDone <= 2'b00;
		rd(OFF_CONTROL); chk("soft done", v, SOFT_SRC);
		$display("test soft done");
	endtask
	// Reset in mid-run returns the control word and the mask to zero.
	task automatic t_reset();
		wr(OFF_CONTROL, 16'h8081);
		wr(OFF_IRQ_MASK, 16'h0003);
		@(posedge core_clk) rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(OFF_CONTROL); chk("control after reset", v, RST_CONTROL);
		rd(OFF_IRQ_MASK); chk("mask after reset", v, 16'h0000);
		#1 chk("irq after reset", 16'(irq), 16'h0000);
		$display("test reset done");
	endtask
	// Counts, verdict and the end of the run.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Main sequence; reset is released at a rising edge, so the first request meets a clean edge.
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_hw_irq();
		t_noirq();
		t_soft();
		t_reset();
		end_sim();
	end
	// Watchdog well beyond the hundred or so cycles the tests need.
	initial begin
		#50000;
		n_mismatch++;
		end_sim();
	end
endmodule // testbench

// ===== verilog/acp_pair_slot.sv
// One convert pair's control byte: pending flag, self-clearing soft trigger, completion pulse.
`timescale 1ns/1ps
module acp_pair_slot
	import acp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic writeByte,
	input wire logic [PAIR_BYTE_W-1:0] writeValue,
	input wire logic hwTrigger,
	input wire logic convDone,
	output acp_pair_s pairReg,
	output logic irqPulse,
	output logic softRequest
);

	// Registered pair state and next values.
	acp_pair_s next_pairReg;
	logic next_irqPulse;
	logic softSelected;

	assign softSelected = (pairReg.triggerSource == SRC_SOFTWARE);
	// A soft trigger asks for a start only while the software source is chosen.
	assign softRequest = pairReg.softTrigger & softSelected & ~pairReg.pending; // RQ4

	// Next state of the pair byte: software writes, then hardware events take precedence.
	always_comb begin
		next_pairReg = pairReg;
		next_irqPulse = 1'b0;
		if (writeByte) begin
			next_pairReg = acp_pair_s'(writeValue); // RQ6
		end
		// Completion clears the pending flag whatever the enable holds.
		if (convDone && pairReg.pending) begin
			next_pairReg.pending = 1'b0; // RQ2 RQ7
			next_irqPulse = pairReg.irqEnable; // RQ1 RQ7
		end
		// A trigger sets pending and wins over a clearing write in the same cycle.
		if (hwTrigger) begin
			next_pairReg.pending = 1'b1; // RQ2
			next_pairReg.softTrigger = 1'b0; // RQ3
		end
	end

	// Register the pair byte.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pairReg <= acp_pair_s'(RST_CONTROL[PAIR_BYTE_W-1:0]);
			irqPulse <= 1'b0;
		end else begin
			pairReg <= next_pairReg;
			irqPulse <= next_irqPulse;
		end
	end

	// Pending flag rises one cycle after the selected trigger asserts.
	property p_trig_sets_pending;
		@(posedge core_clk) disable iff (!rst_n)
		hwTrigger |=> pairReg.pending && !pairReg.softTrigger;
	endproperty
	a_trig_sets_pending: assert property (p_trig_sets_pending) // RQ2
		else $error("Trigger did not set pending and clear soft trigger.");

	// Completion without a trigger clears pending.
	property p_done_clears;
		@(posedge core_clk) disable iff (!rst_n)
		(convDone && pairReg.pending && !hwTrigger && !writeByte) |=> !pairReg.pending;
	endproperty
	a_done_clears: assert property (p_done_clears) // RQ7
		else $error("Completion did not clear pending.");

	// Interrupt pulse follows completion only when enabled.
	property p_irq_cause;
		@(posedge core_clk) disable iff (!rst_n)
		irqPulse |-> $past(convDone && pairReg.pending && pairReg.irqEnable);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // RQ1
		else $error("Interrupt pulse without enabled completion.");

	// Enabled completion always yields a pulse.
	property p_irq_given;
		@(posedge core_clk) disable iff (!rst_n)
		(convDone && pairReg.pending && pairReg.irqEnable) |=> irqPulse;
	endproperty
	a_irq_given: assert property (p_irq_given) // RQ1
		else $error("Enabled completion produced no pulse.");

	// The pulse is one cycle wide.
	property p_irq_single;
		@(posedge core_clk) disable iff (!rst_n)
		irqPulse |=> !irqPulse;
	endproperty
	a_irq_single: assert property (p_irq_single) // RQ7
		else $error("Interrupt pulse longer than one cycle.");

endmodule // acp_pair_slot

// ===== verilog/acp_pair_trigger_control.sv
// Top of the two-pair converter trigger control block with register port and interrupt.
// Behaviour
// RQ1: enabled pair raises interrupt on completion
// RQ2: pending sets on trigger, clears on completion
// RQ3: soft trigger starts pair, clears when pending
// RQ4: software selects soft source before triggering
// RQ5: soft request waits until converter is free
// RQ6: high pair upper byte, fields enable-pending-soft-source
// RQ7: completion clears pending; one pulse per completion
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module acp_pair_trigger_control
	import acp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input acp_bus_req_s busReq,
	input wire logic [PAIRS-1:0] hwTriggerIn,
	input wire logic convBusy,
	input wire logic [PAIRS-1:0] convDone,
	output logic [DATA_W-1:0] rdData,
	output logic [PAIRS-1:0] convStart,
	output logic irq
);

	// Pair bytes, completion pulses and soft start requests per pair.
	acp_pair_s pairRegs [PAIRS];
	logic [PAIRS-1:0] pairIrq;
	logic [PAIRS-1:0] softReq;
	logic [PAIRS-1:0] pairTrigger;
	logic [DATA_W-1:0] controlWord;
	// Interrupt status and mask, one bit per pair.
	logic [PAIRS-1:0] irqStatus, next_irqStatus;
	logic [PAIRS-1:0] irqMask, next_irqMask;
	logic [DATA_W-1:0] next_rdData;
	logic next_irq;
	// Start sequencer.
	acp_state_e state, next_state;
	logic [PAIRS-1:0] next_convStart;
	logic [PAIRS-1:0] softGrant;
	logic writeControl;
	// Write-one-to-clear decode of the status register, one bit per pair.
	logic [PAIRS-1:0] statusClear;

	assign writeControl = busReq.wrStrobe && (busReq.addr == OFF_CONTROL);

	// The sticky check reads this decode, so it sees exactly what a status write asked to clear.
	// Bits not named by a write stay zero here and can never wipe a flag.
	assign statusClear = (busReq.wrStrobe && busReq.addr == OFF_IRQ_STATUS)
		? busReq.wrData[PAIRS-1:0] : '0;

	// One slot per pair; pair 0 is the low byte, pair 1 the high byte.
	genvar gi;
	generate
		for (gi = 0; gi < PAIRS; gi++) begin : g_pair
			// A pair's trigger is its hardware source or a granted soft request.
			assign pairTrigger[gi] = hwTriggerIn[gi] | softGrant[gi]; // RQ3
			assign controlWord[gi*PAIR_BYTE_W +: PAIR_BYTE_W] = pairRegs[gi]; // RQ6
			acp_pair_slot u_slot (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.writeByte(writeControl),
				.writeValue(busReq.wrData[gi*PAIR_BYTE_W +: PAIR_BYTE_W]),
				.hwTrigger(pairTrigger[gi]),
				.convDone(convDone[gi]),
				.pairReg(pairRegs[gi]),
				.irqPulse(pairIrq[gi]),
				.softRequest(softReq[gi])
			);
		end
	endgenerate

	// Soft grants only while the converter is idle; the lower pair wins a tie.
	// Held requests simply stay in the soft trigger bit until resources free up.
	always_comb begin
		softGrant = '0;
		if (state == ST_IDLE && !convBusy) begin
			if (softReq[0]) begin
				softGrant[0] = 1'b1; // RQ5
			end else if (softReq[1]) begin
				softGrant[1] = 1'b1; // RQ5
			end
		end
	end

	// Sequencer: a start pulse goes out the cycle after the grant, then waits for busy to drop.
	always_comb begin
		next_state = state;
		next_convStart = pairTrigger;
		case (state)
			ST_IDLE: begin
				if (|softGrant) begin
					next_state = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				// Give the core one cycle to report busy before judging it free.
				if (!convBusy && !(|convStart)) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Interrupt status: completions set, write-one clears, set wins; mask and read data.
	always_comb begin
		next_irqStatus = irqStatus;
		next_irqMask = irqMask;
		next_rdData = '0;
		if (busReq.wrStrobe && busReq.addr == OFF_IRQ_STATUS) begin
			next_irqStatus = irqStatus & ~busReq.wrData[PAIRS-1:0];
		end
		next_irqStatus = next_irqStatus | pairIrq; // RQ1
		if (busReq.wrStrobe && busReq.addr == OFF_IRQ_MASK) begin
			next_irqMask = busReq.wrData[PAIRS-1:0];
		end
		// Address decode for reads; unmapped addresses read zero.
		if (busReq.rdStrobe) begin
			if (busReq.addr == OFF_CONTROL) begin
				next_rdData = controlWord; // RQ6
			end else if (busReq.addr == OFF_IRQ_STATUS) begin
				next_rdData = {{(DATA_W-PAIRS){1'b0}}, irqStatus};
			end else if (busReq.addr == OFF_IRQ_MASK) begin
				next_rdData = {{(DATA_W-PAIRS){1'b0}}, irqMask};
			end else if (busReq.addr == OFF_BUSY) begin
				next_rdData = {{(DATA_W-1){1'b0}}, state == ST_CONVERT};
			end
		end
		next_irq = |(next_irqStatus & next_irqMask);
	end

	// Register all top-level state so every output comes from a flip-flop.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			convStart <= RST_PAIRS;
			irqStatus <= RST_PAIRS;
			irqMask <= RST_PAIRS;
			rdData <= RST_CONTROL;
			irq <= 1'b0;
		end else begin
			state <= next_state;
			convStart <= next_convStart;
			irqStatus <= next_irqStatus;
			irqMask <= next_irqMask;
			rdData <= next_rdData;
			irq <= next_irq;
		end
	end

	// A soft request while busy produces no start on the next cycle.
	property p_hold_busy;
		@(posedge core_clk) disable iff (!rst_n)
		(convBusy && !(|hwTriggerIn)) |=> convStart == '0;
	endproperty
	a_hold_busy: assert property (p_hold_busy) // RQ5
		else $error("Start issued while converter busy.");

	// Soft start, first step: a held soft request meets a free, idle converter.
	sequence s_soft_free;
		softReq[0] && !convBusy && state == ST_IDLE;
	endsequence

	// Second step: the start pulse leaves with pending set and the soft bit dropped.
	sequence s_soft_started;
		convStart[0] && pairRegs[0].pending && !pairRegs[0].softTrigger;
	endsequence

	// Third step: the sequencer counts itself busy while the start is in flight.
	sequence s_seq_waiting;
		state == ST_CONVERT;
	endsequence

	// A low-pair soft request on a free, idle converter starts within one cycle.
	property p_soft_start;
		@(posedge core_clk) disable iff (!rst_n)
		s_soft_free |=> s_soft_started ##0 s_seq_waiting;
	endproperty
	a_soft_start: assert property (p_soft_start) // RQ3
		else $error("Free soft request did not start.");

	// Control reads return the packed pair bytes one cycle later.
	property p_read_control;
		@(posedge core_clk) disable iff (!rst_n)
		(busReq.rdStrobe && busReq.addr == OFF_CONTROL && !busReq.wrStrobe)
			|=> rdData == $past(controlWord);
	endproperty
	a_read_control: assert property (p_read_control) // RQ6
		else $error("Control read data mismatch.");

	// The interrupt line follows unmasked status with no lag.
	// Both sides are registered from the same next values, so any skew means a broken path.
	property p_irq_level;
		@(posedge core_clk) disable iff (!rst_n)
		irq == (|(irqStatus & irqMask));
	endproperty
	a_irq_level: assert property (p_irq_level) // RQ1
		else $error("Interrupt line disagrees with unmasked status.");

	// A status bit that no write clears stays set on the next cycle.
	// Software that forgets to clear keeps its status bit; nothing else may drop it.
	property p_status_sticky;
		@(posedge core_clk) disable iff (!rst_n)
		(|(irqStatus & ~statusClear)) |=> ((irqStatus & $past(irqStatus & ~statusClear))
			== $past(irqStatus & ~statusClear));
	endproperty
	a_status_sticky: assert property (p_status_sticky) // RQ1
		else $error("Status bit dropped without a clearing write.");

	// A completion pulse sets its status bit even against a clearing write.
	property p_status_set;
		@(posedge core_clk) disable iff (!rst_n)
		(|pairIrq) |=> ((irqStatus & $past(pairIrq)) == $past(pairIrq));
	endproperty
	a_status_set: assert property (p_status_set) // RQ1
		else $error("Completion did not set its status bit.");

	// Once the start pulse is gone and the core is free, the sequencer takes requests again.
	// Without this a held soft request could wait forever behind a stale busy state.
	property p_seq_release;
		@(posedge core_clk) disable iff (!rst_n)
		(state == ST_CONVERT && !convBusy && !(|convStart)) |=> state == ST_IDLE;
	endproperty
	a_seq_release: assert property (p_seq_release) // RQ5
		else $error("Sequencer stayed busy with the converter free.");

endmodule // acp_pair_trigger_control

// ===== verilog/acp_pkg.sv
// Package of constants and carrier types for the convert pair trigger control block.
package acp_pkg;

	// Register port geometry.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register indices; the control register offset is not printed, so these are chosen.
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_BUSY = 4'h3;

	// Field positions inside each byte of the control register.
	localparam int FLD_ENABLE = 7;
	localparam int FLD_PENDING = 6;
	localparam int FLD_SOFT = 5;
	localparam int SRC_W = 5;
	localparam int PAIRS = 2;
	localparam int PAIR_BYTE_W = 8;

	// Reset values.
	localparam logic [DATA_W-1:0] RST_CONTROL = 16'h0000;
	localparam logic [PAIRS-1:0] RST_PAIRS = 2'h0;
	localparam logic [SRC_W-1:0] RST_SRC = 5'h00;

	// Trigger source code meaning individual software trigger; encoding not given, so a parameter.
	localparam logic [SRC_W-1:0] SRC_SOFTWARE = 5'h01;

	// One pair's control byte as it sits in the register.
	typedef struct packed {
		logic irqEnable;
		logic pending;
		logic softTrigger;
		logic [SRC_W-1:0] triggerSource;
	} acp_pair_s;

	// Register port request from the processor side.
	typedef struct packed {
		logic wrStrobe;
		logic rdStrobe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
	} acp_bus_req_s;

	// Sequencer states for starting pair conversions.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT
	} acp_state_e;

endpackage
